// *** sfmc_pkg.sv ***
// Constants and helper functions of the switch forwarding mode register bank
// Functional notes
// - Writable 14-bit ack latency field, resets zero
// - Enable bit selects programmed ack latency value
// - Read-only legacy video decode bit, resets one
// - Management bus or autoload replaces field defaults
// - Bit 0 picks store-forward, else cut-through
// - Bits 2:1 move cut-through start earlier
// - Arbitration bit set: stay on pending port
// - Bit clear: move only to credited requester
// - Credit bit set: release all types together
// - Credit bit clear: release types separately
// - Bit 5 orders packets across egress ports
// - Bit 6 orders completions of different tags
package sfmc_pkg;

  // ****************************************************************
  // Register offsets (byte addresses in configuration space)
  // ****************************************************************
  localparam logic [7:0]  ACK_LAT_OFFSET = 8'h70;   // Ack latency register
  localparam logic [7:0]  OPMODE_OFFSET  = 8'h74;   // Switch operation mode register

  // ****************************************************************
  // Ack latency register layout
  // ****************************************************************
  localparam int          ACK_LAT_LSB    = 0;       // User latency value low bit
  localparam int          ACK_LAT_W      = 14;      // User latency value width
  localparam int          ACK_EN_BIT     = 14;      // User latency enable
  localparam int          VGA_BIT        = 15;      // Legacy video decode enable
  localparam logic [31:0] ACK_LAT_RESET  = 32'h0000_8000; // Value zero, enable 0, video 1
  localparam logic [31:0] ACK_LAT_WMASK  = 32'h0000_7FFF; // Bits software may write
  localparam logic [31:0] ACK_LAT_LMASK  = 32'h0000_FFFF; // Bits a default load may write

  // ****************************************************************
  // Operation mode register layout
  // ****************************************************************
  localparam int          SF_BIT         = 0;       // Store-forward select
  localparam int          THR_LSB        = 1;       // Cut-through threshold low bit
  localparam int          THR_W          = 2;       // Cut-through threshold width
  localparam int          ARB_BIT        = 3;       // Port arbitration mode
  localparam int          CRED_BIT       = 4;       // Credit update mode
  localparam int          ORD_EGR_BIT    = 5;       // Cross egress port ordering
  localparam int          ORD_TAG_BIT    = 6;       // Completion tag ordering
  localparam logic [31:0] OPMODE_RESET   = 32'h0000_0002; // Threshold 01, rest zero
  localparam logic [31:0] OPMODE_WMASK   = 32'h0000_007F; // Implemented bits

  // ****************************************************************
  // Credit types and helpers
  // ****************************************************************
  localparam int          CRED_TYPES     = 3;       // Posted, non-posted, completion

  // Byte-lane merge of a write into a stored word, limited by a mask
  function automatic logic [31:0] sfmc_merge(input logic [31:0] old_word,
                                             input logic [31:0] new_word,
                                             input logic [3:0]  be,
                                             input logic [31:0] mask);
    logic [31:0] lanes;
    lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & mask;
    return (old_word & ~lanes) | (new_word & lanes);
  endfunction

endpackage

// *** sfmc_arbiter.sv ***
// Round-robin port arbiter steered by the port arbitration mode bit
`timescale 1ns/1ns
module sfmc_arbiter #(
  parameter int NPORTS = 4                    // Number of requesting ports
) (
  input  wire logic              clk,           // Core clock
  input  wire logic              reset,         // Synchronous reset, active high
  input  wire logic              hold_mode,     // Stay on granted port while it requests
  input  wire logic [NPORTS-1:0] port_req,      // Packet queued per port
  input  wire logic [NPORTS-1:0] port_credit_ok,// Outgoing credit enough per port
  input  wire logic              pkt_done,      // Granted packet finished
  output logic      [NPORTS-1:0] grant_q,       // One-hot grant
  output logic                   grant_valid_q  // A port holds the grant
);

  localparam int IW = (NPORTS > 1) ? $clog2(NPORTS) : 1;

  // Refuse port counts the index logic cannot serve
  initial begin
    if (NPORTS < 2 || NPORTS > 16) begin
      $error("sfmc_arbiter: NPORTS must be 2 to 16");
    end
  end

  logic [IW-1:0]     idx_q;          // Index of last granted port
  logic [IW-1:0]     idx_d;          // Next index
  logic [NPORTS-1:0] grant_d;        // Next one-hot grant
  logic              grant_valid_d;  // Next grant valid
  logic              keep;           // Current grant stays
  logic [NPORTS-1:0] eligible;       // Requesting with enough credit
  logic [NPORTS-1:0] elig_seen_q;    // Eligibility one cycle back, for checks

  // ****************************************************************
  // Grant selection
  // ****************************************************************
  // Keep or rotate the grant; a new grant needs request and credit
  always_comb begin
    logic [IW-1:0] cand;
    logic          found;
    cand     = '0;
    found    = 1'b0;
    eligible = port_req & port_credit_ok;
    keep     = grant_valid_q && !pkt_done && port_req[idx_q] &&
               (hold_mode || port_credit_ok[idx_q]);
    idx_d         = idx_q;
    grant_d       = grant_q;
    grant_valid_d = grant_valid_q;
    if (!keep) begin
      // Search from the port after the last one granted
      for (int i = 1; i <= NPORTS; i++) begin
        cand = IW'((int'(idx_q) + i) % NPORTS);
        if (!found && eligible[cand]) begin
          found = 1'b1;
          idx_d = cand;
        end
      end
      grant_valid_d = found;
      grant_d       = found ? (NPORTS'(1) << idx_d) : '0;
    end
  end

  // Register the grant
  always_ff @(posedge clk) begin
    if (reset) begin
      idx_q         <= '0;
      grant_q       <= '0;
      grant_valid_q <= 1'b0;
      elig_seen_q   <= '0;
    end else begin
      idx_q         <= idx_d;
      grant_q       <= grant_d;
      grant_valid_q <= grant_valid_d;
      elig_seen_q   <= eligible;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_hold_stays: assert property (@(posedge clk) disable iff (reset)
    (hold_mode && grant_valid_q && port_req[idx_q] && !pkt_done)
      |=> (grant_valid_q && $stable(idx_q)))
    else $error("grant left a pending port in hold mode");

  chk_new_credited: assert property (@(posedge clk) disable iff (reset)
    (grant_valid_q && (!$past(grant_valid_q) || $changed(idx_q)))
      |-> elig_seen_q[idx_q])
    else $error("grant moved to a port without request or credit");

  chk_drop_uncredited: assert property (@(posedge clk) disable iff (reset)
    (!hold_mode && grant_valid_q && !port_credit_ok[idx_q])
      |=> (!grant_valid_q || $changed(idx_q)))
    else $error("grant stayed on a port without credit");

endmodule

// *** sfmc_top.sv ***
// Upstream port forwarding mode and ack latency register bank
`timescale 1ns/1ns
module sfmc_top #(
  parameter int NPORTS = 4,                   // Ports seen by the arbiter
  parameter int CW     = 8                    // Width of cut-through cycle counts
) (
  input  wire logic                 clk,                 // Core clock, 25 MHz
  input  wire logic                 reset,               // Synchronous reset, active high
  // Configuration space access
  input  wire logic                 cfg_wr,              // Write strobe
  input  wire logic                 cfg_rd,              // Read strobe
  input  wire logic [7:0]           cfg_addr,            // Byte address of the word
  input  wire logic [3:0]           cfg_be,              // Byte enables
  input  wire logic [31:0]          cfg_wdata,           // Write data
  output logic      [31:0]          cfg_rdata_q,         // Read data
  output logic                      cfg_rvalid_q,        // Read data valid pulse
  // Default load from management bus or EEPROM autoload
  input  wire logic                 dflt_wr,             // Load strobe
  input  wire logic [7:0]           dflt_addr,           // Byte address of the word
  input  wire logic [31:0]          dflt_wdata,          // Full word to load
  // Ack latency
  input  wire logic [sfmc_pkg::ACK_LAT_W-1:0] ack_latency_internal, // Latency chosen by core
  output logic      [sfmc_pkg::ACK_LAT_W-1:0] ack_latency_q,        // Latency in use
  output logic                      vga_decode_en_q,     // Legacy video decode active
  // Forwarding mode
  output logic                      store_forward_q,     // 1 store-forward, 0 cut-through
  input  wire logic [CW-1:0]        cut_mid_point,       // Middle cycle of packet
  output logic      [CW-1:0]        cut_start_q,         // Cycle to start forwarding
  output logic                      order_egress_q,      // Order across egress ports
  output logic                      order_tag_q,         // Order completions by tag
  // Port arbitration
  input  wire logic [NPORTS-1:0]    port_req,            // Packet queued per port
  input  wire logic [NPORTS-1:0]    port_credit_ok,      // Enough credit per port
  input  wire logic                 pkt_done,            // Granted packet finished
  output logic      [NPORTS-1:0]    grant_q,             // One-hot grant
  output logic                      grant_valid_q,       // Grant held
  // Credit release to the link partner
  input  wire logic                 credit_tick,         // Credit update opportunity
  input  wire logic [sfmc_pkg::CRED_TYPES-1:0] credit_pending,   // New credit waiting per type
  output logic      [sfmc_pkg::CRED_TYPES-1:0] credit_release_q  // Released types, pulse
);

  localparam int ACKW   = sfmc_pkg::ACK_LAT_W;
  localparam int NTYPES = sfmc_pkg::CRED_TYPES;
  localparam int TW     = (NTYPES > 1) ? $clog2(NTYPES) : 1;

  // Refuse count widths the threshold subtraction cannot serve
  initial begin
    if (CW < sfmc_pkg::THR_W) begin
      $error("sfmc_top: CW must be at least the threshold width");
    end
  end

  // ****************************************************************
  // Register storage
  // ****************************************************************
  logic [31:0] ack_reg_q;     // Ack latency register word
  logic [31:0] ack_reg_d;     // Next value
  logic [31:0] mode_reg_q;    // Operation mode register word
  logic [31:0] mode_reg_d;    // Next value

  // Field views of the stored words
  logic [ACKW-1:0]          user_latency;   // Programmed latency
  logic                     user_lat_en;    // Programmed latency enable
  logic [sfmc_pkg::THR_W-1:0] thr_code;     // Cut-through threshold code
  logic                     arb_hold;       // Arbitration hold mode
  logic                     cred_all;       // Release all credit types at once

  assign user_latency = ack_reg_q[sfmc_pkg::ACK_LAT_LSB +: ACKW];
  assign user_lat_en  = ack_reg_q[sfmc_pkg::ACK_EN_BIT];
  assign thr_code     = mode_reg_q[sfmc_pkg::THR_LSB +: sfmc_pkg::THR_W];
  assign arb_hold     = mode_reg_q[sfmc_pkg::ARB_BIT];
  assign cred_all     = mode_reg_q[sfmc_pkg::CRED_BIT];

  // Next register values: a default load wins over a software write
  always_comb begin
    ack_reg_d  = ack_reg_q;
    mode_reg_d = mode_reg_q;
    if (dflt_wr) begin
      // Load replaces defaults, read-only bits included
      if (dflt_addr == sfmc_pkg::ACK_LAT_OFFSET) begin
        ack_reg_d = dflt_wdata & sfmc_pkg::ACK_LAT_LMASK;
      end
      if (dflt_addr == sfmc_pkg::OPMODE_OFFSET) begin
        mode_reg_d = dflt_wdata & sfmc_pkg::OPMODE_WMASK;
      end
    end else if (cfg_wr) begin
      // Software reaches only the writable bits
      if (cfg_addr == sfmc_pkg::ACK_LAT_OFFSET) begin
        ack_reg_d = sfmc_pkg::sfmc_merge(ack_reg_q, cfg_wdata, cfg_be,
                                         sfmc_pkg::ACK_LAT_WMASK);
      end
      if (cfg_addr == sfmc_pkg::OPMODE_OFFSET) begin
        mode_reg_d = sfmc_pkg::sfmc_merge(mode_reg_q, cfg_wdata, cfg_be,
                                          sfmc_pkg::OPMODE_WMASK);
      end
    end
  end

  // Register the words; reset brings back the defaults
  always_ff @(posedge clk) begin
    if (reset) begin
      ack_reg_q  <= sfmc_pkg::ACK_LAT_RESET;
      mode_reg_q <= sfmc_pkg::OPMODE_RESET;
    end else begin
      ack_reg_q  <= ack_reg_d;
      mode_reg_q <= mode_reg_d;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  logic [31:0] rdata_d;   // Next read data
  logic        rvalid_d;  // Next read valid

  // Decode the read address; unmapped words read zero
  always_comb begin
    rvalid_d = cfg_rd;
    rdata_d  = '0;
    if (cfg_rd) begin
      if (cfg_addr == sfmc_pkg::ACK_LAT_OFFSET) begin
        rdata_d = ack_reg_q;
      end else if (cfg_addr == sfmc_pkg::OPMODE_OFFSET) begin
        rdata_d = mode_reg_q;
      end
    end
  end

  // Register read answer
  always_ff @(posedge clk) begin
    if (reset) begin
      cfg_rdata_q  <= '0;
      cfg_rvalid_q <= 1'b0;
    end else begin
      cfg_rdata_q  <= rdata_d;
      cfg_rvalid_q <= rvalid_d;
    end
  end

  // ****************************************************************
  // Mode outputs
  // ****************************************************************
  logic [ACKW-1:0] ack_latency_d;  // Next latency in use
  logic [CW-1:0]   cut_start_d;    // Next cut-through start

  // Pick latency source and place the cut-through start point
  always_comb begin
    ack_latency_d = user_lat_en ? user_latency : ack_latency_internal;
    // Start earlier than the middle by the code, never below zero
    if (cut_mid_point > CW'(thr_code)) begin
      cut_start_d = cut_mid_point - CW'(thr_code);
    end else begin
      cut_start_d = '0;
    end
  end

  // Register the mode outputs
  always_ff @(posedge clk) begin
    if (reset) begin
      ack_latency_q   <= '0;
      vga_decode_en_q <= 1'b1;
      store_forward_q <= 1'b0;
      cut_start_q     <= '0;
      order_egress_q  <= 1'b0;
      order_tag_q     <= 1'b0;
    end else begin
      ack_latency_q   <= ack_latency_d;
      vga_decode_en_q <= ack_reg_q[sfmc_pkg::VGA_BIT];
      store_forward_q <= mode_reg_q[sfmc_pkg::SF_BIT];
      cut_start_q     <= cut_start_d;
      order_egress_q  <= mode_reg_q[sfmc_pkg::ORD_EGR_BIT];
      order_tag_q     <= mode_reg_q[sfmc_pkg::ORD_TAG_BIT];
    end
  end

  // ****************************************************************
  // Credit release
  // ****************************************************************
  logic [TW-1:0]     cred_ptr_q;       // Next type to serve when separate
  logic [TW-1:0]     cred_ptr_d;       // Next pointer
  logic [NTYPES-1:0] credit_release_d; // Next release pulse

  // All pending types at once, or one type per update in turn
  always_comb begin
    logic          found;
    logic [TW-1:0] cand;
    found            = 1'b0;
    cand             = '0;
    cred_ptr_d       = cred_ptr_q;
    credit_release_d = '0;
    if (credit_tick) begin
      if (cred_all) begin
        credit_release_d = credit_pending;
      end else begin
        for (int i = 0; i < NTYPES; i++) begin
          cand = TW'((int'(cred_ptr_q) + i) % NTYPES);
          if (!found && credit_pending[cand]) begin
            found                  = 1'b1;
            credit_release_d[cand] = 1'b1;
            cred_ptr_d             = TW'((int'(cand) + 1) % NTYPES);
          end
        end
      end
    end
  end

  // Register the credit state
  always_ff @(posedge clk) begin
    if (reset) begin
      cred_ptr_q       <= '0;
      credit_release_q <= '0;
    end else begin
      cred_ptr_q       <= cred_ptr_d;
      credit_release_q <= credit_release_d;
    end
  end

  // ****************************************************************
  // Port arbiter
  // ****************************************************************
  // Arbiter follows the arbitration mode bit
  sfmc_arbiter #(
    .NPORTS (NPORTS)
  ) u_arbiter (
    .clk            (clk),
    .reset          (reset),
    .hold_mode      (arb_hold),
    .port_req       (port_req),
    .port_credit_ok (port_credit_ok),
    .pkt_done       (pkt_done),
    .grant_q        (grant_q),
    .grant_valid_q  (grant_valid_q)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_reset_defaults: assert property (@(posedge clk)
    $past(reset) |-> (ack_reg_q == sfmc_pkg::ACK_LAT_RESET &&
                      mode_reg_q == sfmc_pkg::OPMODE_RESET))
    else $error("register defaults wrong after reset");

  chk_user_latency: assert property (@(posedge clk) disable iff (reset)
    user_lat_en |=> (ack_latency_q == $past(user_latency)))
    else $error("programmed latency not applied");

  chk_internal_latency: assert property (@(posedge clk) disable iff (reset)
    !user_lat_en |=> (ack_latency_q == $past(ack_latency_internal)))
    else $error("internal latency not applied");

  chk_video_ro: assert property (@(posedge clk) disable iff (reset)
    (cfg_wr && !dflt_wr) |=> $stable(ack_reg_q[sfmc_pkg::VGA_BIT]))
    else $error("software changed the video decode bit");

  chk_default_load: assert property (@(posedge clk) disable iff (reset)
    (dflt_wr && dflt_addr == sfmc_pkg::ACK_LAT_OFFSET)
      |=> (ack_reg_q == ($past(dflt_wdata) & sfmc_pkg::ACK_LAT_LMASK)))
    else $error("default load not taken");

  chk_cut_start: assert property (@(posedge clk) disable iff (reset)
    (cut_mid_point >= 8'h03) |=> (cut_start_q == $past(cut_mid_point) - $past(thr_code)))
    else $error("cut-through start misplaced");

  chk_credit_all: assert property (@(posedge clk) disable iff (reset)
    (credit_tick && cred_all) |=> (credit_release_q == $past(credit_pending)))
    else $error("credit types not released together");

  chk_credit_single: assert property (@(posedge clk) disable iff (reset)
    (credit_tick && !cred_all && credit_pending != '0)
      |=> ($onehot(credit_release_q) && (credit_release_q & ~$past(credit_pending)) == '0))
    else $error("separate credit release wrong");

  chk_order_bits: assert property (@(posedge clk) disable iff (reset)
    ##1 (order_egress_q == $past(mode_reg_q[sfmc_pkg::ORD_EGR_BIT]) &&
         order_tag_q == $past(mode_reg_q[sfmc_pkg::ORD_TAG_BIT])))
    else $error("ordering mode outputs wrong");

  // Forwarding mode output follows the stored select bit one cycle later
  chk_store_forward: assert property (@(posedge clk) disable iff (reset)
    ##1 (store_forward_q == $past(mode_reg_q[sfmc_pkg::SF_BIT])))
    else $error("store-forward output wrong");

endmodule

// *** sfmc_tb_top.sv ***
// Self-checking testbench of the forwarding mode register bank
`timescale 1ns/1ns
module sfmc_tb_top;
  // ************************************************************
  // Signals
  // ************************************************************
  localparam int NP = 4;                        // Arbiter ports
  localparam int CW = 8;                        // Cut-through count width
  localparam int AW = sfmc_pkg::ACK_LAT_W;      // Ack latency width
  localparam int NT = sfmc_pkg::CRED_TYPES;     // Credit types
  logic          clk = 1'b0;                    // Core clock
  logic          reset;                         // Synchronous reset
  logic          cfg_wr, cfg_rd, dflt_wr;       // Strobes
  logic [7:0]    cfg_addr, dflt_addr;           // Addresses
  logic [3:0]    cfg_be;                        // Byte enables
  logic [31:0]   cfg_wdata, dflt_wdata;         // Write data
  logic [31:0]   cfg_rdata_q;                   // Read data
  logic          cfg_rvalid_q, vga_decode_en_q; // Read valid, video decode
  logic [AW-1:0] ack_latency_internal, ack_latency_q; // Latencies
  logic          store_forward_q, order_egress_q, order_tag_q; // Mode bits
  logic [CW-1:0] cut_mid_point, cut_start_q;    // Cut-through points
  logic [NP-1:0] port_req, port_credit_ok, grant_q; // Arbiter vectors
  logic          pkt_done, grant_valid_q, credit_tick; // Arbiter and credit
  logic [NT-1:0] credit_pending, credit_release_q; // Credit types
  logic [31:0]   seed = 32'hDD64;               // Random state
  logic [31:0]   exp74, d, rv;                  // Expected word, scratch
  logic [3:0]    be;                            // Random lanes
  int            bad_count = 0;                 // Mismatches
  int            tests_run = 0;                 // Comparisons
  int            cycles = 0;                    // Timeout counter

  sfmc_top #(.NPORTS(NP), .CW(CW)) i_dut (.clk(clk), .reset(reset), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_rdata_q(cfg_rdata_q), .cfg_rvalid_q(cfg_rvalid_q), .dflt_wr(dflt_wr),
    .dflt_addr(dflt_addr), .dflt_wdata(dflt_wdata),
    .ack_latency_internal(ack_latency_internal), .ack_latency_q(ack_latency_q),
    .vga_decode_en_q(vga_decode_en_q), .store_forward_q(store_forward_q),
    .cut_mid_point(cut_mid_point), .cut_start_q(cut_start_q),
    .order_egress_q(order_egress_q), .order_tag_q(order_tag_q), .port_req(port_req),
    .port_credit_ok(port_credit_ok), .pkt_done(pkt_done), .grant_q(grant_q),
    .grant_valid_q(grant_valid_q), .credit_tick(credit_tick),
    .credit_pending(credit_pending), .credit_release_q(credit_release_q));

  // ************************************************************
  // Clock, timeout and helpers
  // ************************************************************
  // Clock at 25 MHz
  always #20 clk = ~clk;

  // Cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      final_report();
    end
  end

  // Xorshift random source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Cut-through start: midpoint minus code, floor at zero
  function automatic logic [CW-1:0] cut_exp(input logic [CW-1:0] m, input logic [1:0] c);
    return (m > CW'(c)) ? m - CW'(c) : '0;
  endfunction

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t ns: %s got %h want %h", $time, msg, got, exp);
    end
  endtask

  // Wait n edges, then settle
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Configuration write; returns when fields are out
  task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] v);
    @(posedge clk);
    cfg_wr    <= 1'b1;
    cfg_addr  <= a;
    cfg_be    <= b;
    cfg_wdata <= v;
    @(posedge clk);
    cfg_wr    <= 1'b0;
    step(1);
  endtask

  // Configuration read with valid check
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    cfg_rd   <= 1'b1;
    cfg_addr <= a;
    @(posedge clk);
    cfg_rd   <= 1'b0;
    #1;
    v = cfg_rdata_q;
    chk(32'(cfg_rvalid_q), 32'h1, "read valid");
    step(1);
    chk(32'(cfg_rvalid_q), 32'h0, "read valid falls");
  endtask

  // Default load as by management bus or autoload
  task automatic dl(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    dflt_wr    <= 1'b1;
    dflt_addr  <= a;
    dflt_wdata <= v;
    @(posedge clk);
    dflt_wr    <= 1'b0;
    step(1);
  endtask

  // Counts and verdict
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    {reset, cfg_wr, cfg_rd, dflt_wr, pkt_done, credit_tick} = 6'h20;
    {cfg_addr, dflt_addr, cfg_be, cfg_wdata, dflt_wdata} = '0;
    {port_req, port_credit_ok, credit_pending} = '0;
    ack_latency_internal = 14'h1A5;
    cut_mid_point = 8'h40;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    step(2);
    // Reset values and unmapped read
    chk(32'(vga_decode_en_q), 32'h1, "video decode after reset");
    chk(32'(ack_latency_q), 32'h1A5, "internal latency");
    rd(8'h70, rv);
    chk(rv, 32'h0000_8000, "ack reg reset");
    rd(8'h74, rv);
    chk(rv, 32'h0000_0002, "mode reg reset");
    rd(8'h44, rv);
    chk(rv, 32'h0, "unmapped read");
    chk(32'(cut_start_q), 32'h3F, "cut start reset");
    $display("test reset done");
    // Credit release per type, then all together
    @(posedge clk);
    credit_tick    <= 1'b1;
    credit_pending <= 3'b101;
    step(1);
    chk(32'(credit_release_q), 32'h1, "first type");
    @(posedge clk);
    credit_tick <= 1'b0;
    #1;
    chk(32'(credit_release_q), 32'h4, "next type");
    wr(8'h74, 4'hF, 32'h12);
    @(posedge clk);
    credit_tick    <= 1'b1;
    credit_pending <= 3'b111;
    @(posedge clk);
    credit_tick <= 1'b0;
    #1;
    chk(32'(credit_release_q), 32'h7, "all types");
    $display("test credit done");
    // Random mode writes with a saturating corner first
    exp74 = 32'h12;
    for (int i = 0; i < 12; i++) begin
      d  = rnd();
      be = 4'(rnd() >> 5);
      @(posedge clk);
      cut_mid_point <= (i == 0) ? 8'h02 : CW'(rnd());
      if (i == 0) begin
        d  = 32'h6;
        be = 4'h1;
      end
      wr(8'h74, be, d);
      for (int k = 0; k < 4; k++) begin
        if (be[k]) begin
          exp74[k*8 +: 8] = d[k*8 +: 8] & 8'h7F >> (k > 0 ? 8 : 0);
        end
      end
      rd(8'h74, rv);
      chk(rv, exp74, "mode word");
      chk(32'(store_forward_q), 32'(exp74[0]), "store forward");
      chk(32'(cut_start_q), 32'(cut_exp(cut_mid_point, exp74[2:1])), "cut start");
      chk(32'(order_egress_q), 32'(exp74[5]), "egress order");
      chk(32'(order_tag_q), 32'(exp74[6]), "tag order");
    end
    $display("test mode done");
    // Ack latency field, enable and read-only video bit
    wr(8'h70, 4'hF, 32'h0000_7FFF & 32'h0000_3FFF | 32'h0000_4000);
    rd(8'h70, rv);
    chk(rv, 32'h0000_FFFF, "ack reg word");
    chk(32'(ack_latency_q), 32'h3FFF, "user latency");
    wr(8'h70, 4'h2, 32'h0);
    ack_latency_internal <= AW'(rnd());
    step(2);
    chk(32'(ack_latency_q), 32'(ack_latency_internal), "internal again");
    // Default loads, winning over a same-cycle write
    dl(8'h70, 32'h0000_4123);
    chk(32'(vga_decode_en_q), 32'h0, "loaded video bit");
    chk(32'(ack_latency_q), 32'h0123, "loaded latency");
    @(posedge clk);
    {cfg_wr, dflt_wr, cfg_be, cfg_addr, dflt_addr} <= {2'b11, 4'hF, 8'h74, 8'h74};
    {cfg_wdata, dflt_wdata} <= {32'h7F, 32'h0};
    @(posedge clk);
    {cfg_wr, dflt_wr} <= 2'b00;
    rd(8'h74, rv);
    chk(rv, 32'h0, "load beats write");
    $display("test latency and load done");
    // Arbiter: credit needed to move or stay, then hold mode
    @(posedge clk);
    {port_req, port_credit_ok} <= {4'b0011, 4'b0010};
    step(2);
    chk(32'(grant_q), 32'h2, "credited port only");
    @(posedge clk);
    port_credit_ok <= 4'b0000;
    step(2);
    chk(32'(grant_valid_q), 32'h0, "grant dropped");
    @(posedge clk);
    port_credit_ok <= 4'b0010;
    wr(8'h74, 4'h1, 32'h08);
    @(posedge clk);
    port_credit_ok <= 4'b0000;
    step(3);
    chk(32'(grant_q), 32'h2, "grant held");
    @(posedge clk);
    {pkt_done, port_credit_ok} <= {1'b1, 4'b0001};
    @(posedge clk);
    pkt_done <= 1'b0;
    step(1);
    chk(32'(grant_q), 32'h1, "next port");
    $display("test arbiter done");
    final_report();
  end
endmodule
